// ==== bench/host_link.sv ====
`timescale 1ns/10ps
module host_link (
	input  wire logic clk_i,     // Core clock, paces the link.
	input  wire logic line_i,    // Resolved level of the data line.
	output logic      sclk_o,    // Link clock, idle high.
	output logic      mode_o,    // Mode line, low for address or halt.
	output logic      data_o,    // Data bit driven by the host.
	output logic      data_oe_o  // High while the host drives data.
);
	// ==========================================================================
	// Link pacing: low phases last 60 ns and high phases alternate 60 and 70 ns,
	// so the link clock period averages 125 ns with every change on a falling
	// core clock edge.
	localparam int HALF = 6;
	logic          ph;

	initial begin
		ph = 1'b0;
		sclk_o = 1'b1;
		mode_o = 1'b0;
		data_o = 1'b0;
		data_oe_o = 1'b0;
	end

	// ==========================================================================
	// Link primitives; every change lands on a falling core clock edge.
	task automatic wt(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	task automatic set_mode(input logic m);
		mode_o = m;
	endtask

	task automatic bit_cycle(input logic d, input logic drv, output logic s);
		sclk_o = 1'b0;
		data_oe_o = drv;
		data_o = d;
		wt(HALF);
		s = line_i;
		sclk_o = 1'b1;
		wt(HALF + int'(ph));
		ph = ~ph;
	endtask

	task automatic address(input logic [7:0] a);
		logic s;
		mode_o = 1'b0;
		wt(HALF);
		for (int i = 0; i < 8; i++) bit_cycle(a[i], 1'b1, s);
		data_oe_o = 1'b0;
		mode_o = 1'b1;
		wt(HALF);
	endtask

	// The host keeps driving after a written byte, so back-to-back bytes need no release.
	task automatic put(input logic [7:0] b);
		logic s;
		for (int i = 0; i < 8; i++) bit_cycle(b[i], 1'b1, s);
	endtask

	task automatic get(output logic [7:0] b);
		for (int i = 0; i < 8; i++) bit_cycle(1'b0, 1'b0, b[i]);
	endtask

	// The clock stays high through the pause so it cannot be taken for addressing.
	task automatic halt();
		mode_o = 1'b0;
		wt(HALF);
		mode_o = 1'b1;
		wt(HALF);
	endtask
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/10ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
	$display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); end end
module tb;
	// ==========================================================================
	// Clock, reset and wiring.
	logic       clk_i   = 1'b0;
	logic       nrst_i;
	logic       rdy;
	logic [7:0] rd_data;
	logic       sclk, mode, host_d, host_oe, dev_d, dev_oe, dir, rd_p, wr_p;
	logic [7:0] sel, pos, wr_data, ll, lr, rl, rr, got;
	int         n_errors = 0;
	int         n_checks = 0;
	int         n_wr     = 0;
	int         n_rd     = 0;
	// An undriven data line floats high through its pull-up.
	wire        line_w   = dev_oe ? dev_d : (host_oe ? host_d : 1'b1);

	always #5 clk_i = ~clk_i;
	always @(negedge clk_i) rd_data <= 8'hA5 ^ pos;
	always @(posedge clk_i) if (wr_p === 1'b1) n_wr <= n_wr + 1;
	always @(posedge clk_i) if (rd_p === 1'b1) n_rd <= n_rd + 1;

	host_link host_u (.clk_i(clk_i), .line_i(line_w), .sclk_o(sclk), .mode_o(mode),
		.data_o(host_d), .data_oe_o(host_oe));

	host_serial_port dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .serial_clock_line_i(sclk),
		.mode_select_line_i(mode), .serial_data_line_i(line_w), .serial_data_line_o(dev_d),
		.serial_data_line_oe_o(dev_oe), .port_ready_flag_i(rdy), .item_rd_data_i(rd_data),
		.item_sel_o(sel), .item_pos_o(pos), .item_dir_o(dir), .item_rd_o(rd_p),
		.item_wr_o(wr_p), .item_wr_data_o(wr_data), .left_to_left_coef_o(ll),
		.left_to_right_coef_o(lr), .right_to_left_coef_o(rl), .right_to_right_coef_o(rr));

	// ==========================================================================
	// Scenarios.
	task complete_run;
		$display("Checks %0d, errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic select(input logic [7:0] c);
		host_u.address(serial_port_pkg::OP_WR_CTRL);
		host_u.put(c);
	endtask

	task automatic poll_ready();
		`CHK(dev_oe, 1'b0)
		host_u.address(serial_port_pkg::OP_RD_STAT);
		`CHK({dev_oe, line_w}, 2'b11)
		rdy = 1'b0;
		host_u.wt(6);
		`CHK({dev_oe, line_w}, 2'b10)
		rdy = 1'b1;
		host_u.wt(6);
		`CHK(line_w, 1'b1)
		host_u.set_mode(1'b0);
		host_u.wt(5);
		`CHK(dev_oe, 1'b0)
	endtask

	task automatic read_item();
		int base;
		base = n_rd;
		select(8'h15);
		host_u.address(serial_port_pkg::OP_RD_ITEM);
		host_u.get(got);
		`CHK(got, 8'hA5)
		host_u.get(got);
		`CHK(got, 8'hA4)
		`CHK({sel, pos, dir}, {8'h15, 8'h02, 1'b1})
		`CHK(n_rd - base, 2)
	endtask

	task automatic coef_suspend();
		select(serial_port_pkg::CTL_COEF);
		host_u.address(serial_port_pkg::OP_WR_ITEM);
		host_u.put(8'h11);
		host_u.halt();
		for (int i = 2; i < 6; i++) host_u.put(8'(i * 17));
		`CHK(ll, 8'h55)
		`CHK({lr, rl, rr}, 24'h223344)
		host_u.address(serial_port_pkg::OP_RD_STAT);
		rdy = 1'b0;
		host_u.get(got);
		`CHK(got, 8'h01)
		select(serial_port_pkg::CTL_COEF);
		host_u.address(serial_port_pkg::OP_WR_ITEM);
		host_u.put(8'h66);
		`CHK(ll, 8'h66)
		select(serial_port_pkg::CTL_RESUME);
		host_u.address(serial_port_pkg::OP_RD_STAT);
		host_u.get(got);
		`CHK(got, 8'h00)
		rdy = 1'b1;
		for (int i = 0; i < 4 && got[0] !== 1'b1; i++) host_u.get(got);
		`CHK(got, 8'h01)
		host_u.address(serial_port_pkg::OP_RD_ITEM);
		host_u.get(got);
		`CHK(got, 8'hA7)
		`CHK({sel, dir}, {8'h15, 1'b1})
	endtask

	task automatic write_item();
		int base;
		base = n_wr;
		select(8'h22);
		host_u.address(serial_port_pkg::OP_WR_ITEM);
		host_u.put(8'h3C);
		host_u.put(8'hC3);
		`CHK({wr_data, pos, dir}, {8'hC3, 8'h02, 1'b0})
		`CHK(n_wr - base, 2)
		`CHK(ll, 8'h66)
	endtask

	// ==========================================================================
	// Main sequence and watchdog.
	initial begin
		nrst_i = 1'b0;
		rdy = 1'b1;
		repeat (12) @(negedge clk_i);
		nrst_i = 1'b1;
		host_u.wt(4);
		poll_ready();
		read_item();
		coef_suspend();
		write_item();
		complete_run();
	end

	initial begin
		// The scenarios need about 3400 cycles; this leaves ample margin.
		repeat (20000) @(posedge clk_i);
		n_errors++;
		$display("Watchdog expired before the scenarios ended");
		complete_run();
	end
endmodule

// ==== hdl/host_serial_port.sv ====
`timescale 1ns/10ps
module host_serial_port (
	input  wire logic       clk_i,                      // Core clock, 100 MHz.
	input  wire logic       nrst_i,                     // Synchronous reset, active low.
	input  wire logic       serial_clock_line_i,        // Link clock from the host.
	input  wire logic       mode_select_line_i,         // Link mode from the host.
	input  wire logic       serial_data_line_i,         // Link data, pin level.
	output logic            serial_data_line_o,         // Link data driven by the device.
	output logic            serial_data_line_oe_o,      // High while the device drives data.
	input  wire logic       port_ready_flag_i,          // Core ready for item bytes.
	input  wire logic [7:0] item_rd_data_i,             // Item byte at item_pos_o.
	output logic [7:0]      item_sel_o,                 // Selected item control byte.
	output logic [7:0]      item_pos_o,                 // Byte index within the item.
	output logic            item_dir_o,                 // Item direction, high for read.
	output logic            item_rd_o,                  // Pulse: item byte was sent.
	output logic            item_wr_o,                  // Pulse: item byte received.
	output logic [7:0]      item_wr_data_o,             // Received item byte.
	output logic [7:0]      left_to_left_coef_o,        // Coefficient left to left.
	output logic [7:0]      left_to_right_coef_o,       // Coefficient left to right.
	output logic [7:0]      right_to_left_coef_o,       // Coefficient right to left.
	output logic [7:0]      right_to_right_coef_o       // Coefficient right to right.
);

	localparam int EN_MAX = serial_port_pkg::ENABLE_MAX_CYC;

	function automatic logic is_read(input logic [7:0] op);
		is_read = (op == serial_port_pkg::OP_RD_ITEM) || (op == serial_port_pkg::OP_RD_STAT);
	endfunction

	// ==========================================================================
	// Line synchronisers.
	logic [1:0] clk_sync_q;
	logic [1:0] mode_sync_q;
	logic [1:0] data_sync_q;
	logic       clk_prev_q;
	logic       mode_prev_q;

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			clk_sync_q  <= 2'h3;
			mode_sync_q <= 2'h0;
			data_sync_q <= 2'h0;
			clk_prev_q  <= 1'b1;
			mode_prev_q <= 1'b0;
		end else begin
			clk_sync_q  <= {clk_sync_q[0], serial_clock_line_i};
			mode_sync_q <= {mode_sync_q[0], mode_select_line_i};
			data_sync_q <= {data_sync_q[0], serial_data_line_i};
			clk_prev_q  <= clk_sync_q[1];
			mode_prev_q <= mode_sync_q[1];
		end
	end

	logic clk_rise, mode_s, mode_rise, mode_fall;
	assign clk_rise  = clk_sync_q[1] && !clk_prev_q;
	assign mode_s    = mode_sync_q[1];
	assign mode_rise = mode_s && !mode_prev_q;
	assign mode_fall = !mode_s && mode_prev_q;

	// ==========================================================================
	// Protocol state.
	serial_port_pkg::link_mode_e lm_q, lm_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] rx_q, rx_d;
	logic [7:0] op_q, op_d;
	logic       coef_mode_q, coef_mode_d;
	logic [1:0] ptr_q, ptr_d;
	logic [7:0] coef_q [serial_port_pkg::COEF_NUM];
	logic [7:0] coef_d [serial_port_pkg::COEF_NUM];
	logic [7:0] sel_q, sel_d, sav_sel_q, sav_sel_d;
	logic [7:0] pos_q, pos_d, sav_pos_q, sav_pos_d;
	logic       dir_q, dir_d, sav_dir_q, sav_dir_d;
	logic       susp_q, susp_d;
	logic       rd_q, rd_d, wr_q, wr_d;
	logic [7:0] wr_data_q, wr_data_d;
	logic       sdo_q, sdo_d, oe_q, oe_d;
	logic       rdy_eff, byte_done;
	logic [7:0] byte_in;

	assign rdy_eff   = coef_mode_q || port_ready_flag_i;
	assign byte_in   = {data_sync_q[1], rx_q[7:1]};
	assign byte_done = (lm_q == serial_port_pkg::LM_DATA) && mode_s && clk_rise
		&& (cnt_q[2:0] == serial_port_pkg::LAST_BIT);

	always_comb begin
		lm_d        = lm_q;
		cnt_d       = cnt_q;
		rx_d        = rx_q;
		op_d        = op_q;
		coef_mode_d = coef_mode_q;
		ptr_d       = ptr_q;
		coef_d      = coef_q;
		sel_d       = sel_q;
		pos_d       = pos_q;
		dir_d       = dir_q;
		sav_sel_d   = sav_sel_q;
		sav_pos_d   = sav_pos_q;
		sav_dir_d   = sav_dir_q;
		susp_d      = susp_q;
		rd_d        = 1'b0;
		wr_d        = 1'b0;
		wr_data_d   = wr_data_q;
		if (mode_fall) begin
			lm_d  = serial_port_pkg::LM_ADDR;
			cnt_d = 4'h0;
		end else if (mode_rise) begin
			lm_d  = serial_port_pkg::LM_DATA;
			cnt_d = 4'h0;
			if (cnt_q == serial_port_pkg::ADDR_FULL) begin
				op_d = rx_q;
			end
		end else if (clk_rise) begin
			rx_d = byte_in;
			if (lm_q == serial_port_pkg::LM_ADDR) begin
				if (cnt_q != serial_port_pkg::ADDR_FULL) begin
					cnt_d = cnt_q + 4'h1;
				end
			end else if (cnt_q[2:0] == serial_port_pkg::LAST_BIT) begin
				cnt_d = 4'h0;
			end else begin
				cnt_d = cnt_q + 4'h1;
			end
		end
		if (byte_done) begin
			case (op_q)
				serial_port_pkg::OP_WR_CTRL: begin
					if (byte_in == serial_port_pkg::CTL_COEF) begin
						if (!coef_mode_q) begin
							sav_sel_d = sel_q;
							sav_pos_d = pos_q;
							sav_dir_d = dir_q;
							susp_d    = 1'b1;
						end
						coef_mode_d = 1'b1;
						ptr_d       = serial_port_pkg::COEF_FIRST;
					end else if (byte_in == serial_port_pkg::CTL_RESUME) begin
						coef_mode_d = 1'b0;
						if (susp_q) begin
							sel_d  = sav_sel_q;
							pos_d  = sav_pos_q;
							dir_d  = sav_dir_q;
							susp_d = 1'b0;
						end
					end else begin
						coef_mode_d = 1'b0;
						susp_d      = 1'b0;
						sel_d       = byte_in;
						pos_d       = serial_port_pkg::POS_START;
					end
				end
				serial_port_pkg::OP_WR_ITEM: begin
					if (coef_mode_q) begin
						coef_d[ptr_q] = byte_in;
						ptr_d = (ptr_q == serial_port_pkg::COEF_LAST)
							? serial_port_pkg::COEF_FIRST : ptr_q + 2'h1;
					end else begin
						wr_d      = 1'b1;
						wr_data_d = byte_in;
						dir_d     = 1'b0;
						pos_d     = pos_q + 8'h01;
					end
				end
				serial_port_pkg::OP_RD_ITEM: begin
					rd_d  = 1'b1;
					dir_d = 1'b1;
					pos_d = pos_q + 8'h01;
				end
				default: ;
			endcase
		end
	end

	// ==========================================================================
	// Data line driver.
	always_comb begin
		oe_d  = (lm_q == serial_port_pkg::LM_DATA) && mode_s && is_read(op_q);
		sdo_d = 1'b0;
		if (op_q == serial_port_pkg::OP_RD_ITEM) begin
			sdo_d = item_rd_data_i[cnt_q[2:0]];
		end else if (op_q == serial_port_pkg::OP_RD_STAT && cnt_q[2:0] == 3'h0) begin
			sdo_d = rdy_eff;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			lm_q        <= serial_port_pkg::LM_ADDR;
			cnt_q       <= 4'h0;
			rx_q        <= 8'h00;
			op_q        <= serial_port_pkg::OP_NONE;
			coef_mode_q <= 1'b0;
			ptr_q       <= serial_port_pkg::COEF_FIRST;
			for (int i = 0; i < serial_port_pkg::COEF_NUM; i++) begin
				coef_q[i] <= serial_port_pkg::COEF_RESET;
			end
			sel_q       <= serial_port_pkg::SEL_NONE;
			pos_q       <= serial_port_pkg::POS_START;
			dir_q       <= 1'b0;
			sav_sel_q   <= serial_port_pkg::SEL_NONE;
			sav_pos_q   <= serial_port_pkg::POS_START;
			sav_dir_q   <= 1'b0;
			susp_q      <= 1'b0;
			rd_q        <= 1'b0;
			wr_q        <= 1'b0;
			wr_data_q   <= 8'h00;
			sdo_q       <= 1'b0;
			oe_q        <= 1'b0;
		end else begin
			lm_q        <= lm_d;
			cnt_q       <= cnt_d;
			rx_q        <= rx_d;
			op_q        <= op_d;
			coef_mode_q <= coef_mode_d;
			ptr_q       <= ptr_d;
			coef_q      <= coef_d;
			sel_q       <= sel_d;
			pos_q       <= pos_d;
			dir_q       <= dir_d;
			sav_sel_q   <= sav_sel_d;
			sav_pos_q   <= sav_pos_d;
			sav_dir_q   <= sav_dir_d;
			susp_q      <= susp_d;
			rd_q        <= rd_d;
			wr_q        <= wr_d;
			wr_data_q   <= wr_data_d;
			sdo_q       <= sdo_d;
			oe_q        <= oe_d;
		end
	end

	assign serial_data_line_o    = sdo_q;
	assign serial_data_line_oe_o = oe_q;
	assign item_sel_o            = sel_q;
	assign item_pos_o            = pos_q;
	assign item_dir_o            = dir_q;
	assign item_rd_o             = rd_q;
	assign item_wr_o             = wr_q;
	assign item_wr_data_o        = wr_data_q;
	assign left_to_left_coef_o   = coef_q[0];
	assign left_to_right_coef_o  = coef_q[1];
	assign right_to_left_coef_o  = coef_q[2];
	assign right_to_right_coef_o = coef_q[3];

	// ==========================================================================
	// Checks.
	drive_on_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		mode_rise && is_read(op_d) |-> ##[1:EN_MAX] oe_q)
		else $error("data driver not enabled after mode rise");
	drive_off_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!mode_s |=> !oe_q)
		else $error("data driver still on after mode fall");
	poll_copy_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		op_q == serial_port_pkg::OP_RD_STAT && cnt_q == 4'h0 |=> sdo_q == $past(rdy_eff))
		else $error("ready flag not copied to data line");
	coef_ready_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		coef_mode_q && op_q == serial_port_pkg::OP_RD_STAT && cnt_q == 4'h0 |=> sdo_q)
		else $error("ready low during coefficient writes");
	coef_step_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		byte_done && coef_mode_q && op_q == serial_port_pkg::OP_WR_ITEM
		|=> ptr_q == (($past(ptr_q) == 2'h3) ? 2'h0 : $past(ptr_q) + 2'h1))
		else $error("coefficient pointer out of order");
	coef_store_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		byte_done && coef_mode_q && op_q == serial_port_pkg::OP_WR_ITEM && ptr_q == 2'h0
		|=> left_to_left_coef_o == $past(byte_in) && !item_wr_o)
		else $error("first coefficient not stored");
	resume_pos_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		byte_done && susp_q && op_q == serial_port_pkg::OP_WR_CTRL
		&& byte_in == serial_port_pkg::CTL_RESUME |=> pos_q == $past(sav_pos_q) && !susp_q)
		else $error("resume did not restore item position");
	no_nest_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		byte_done && coef_mode_q && op_q == serial_port_pkg::OP_WR_CTRL
		&& byte_in == serial_port_pkg::CTL_COEF |=> sav_pos_q == $past(sav_pos_q))
		else $error("coefficient sequence was suspended");
	item_start_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		byte_done && op_q == serial_port_pkg::OP_WR_CTRL && byte_in != serial_port_pkg::CTL_COEF
		&& byte_in != serial_port_pkg::CTL_RESUME |=> pos_q == 8'h00 ##1 pos_q == 8'h00)
		else $error("item transfer did not start at first byte");
	byte_chain_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		byte_done |=> cnt_q == 4'h0 && lm_q == serial_port_pkg::LM_DATA)
		else $error("no direct continuation into next byte");

endmodule

// ==== hdl/serial_port_pkg.sv ====
package serial_port_pkg;

	// ==========================================================================
	// Byte framing on the data line.
	localparam int          BYTE_BITS  = 8;
	localparam logic [3:0]  ADDR_FULL  = 4'h8;
	localparam logic [2:0]  LAST_BIT   = 3'h7;
	localparam int          POS_W      = 8;
	localparam logic [7:0]  POS_START  = 8'h00;

	// ==========================================================================
	// Operational addresses and control bytes as held after LSB-first assembly.
	localparam logic [7:0]  OP_NONE    = 8'h00;
	localparam logic [7:0]  OP_WR_ITEM = 8'h06;
	localparam logic [7:0]  OP_RD_ITEM = 8'h86;
	localparam logic [7:0]  OP_WR_CTRL = 8'h46;
	localparam logic [7:0]  OP_RD_STAT = 8'hC6;
	localparam logic [7:0]  CTL_COEF   = 8'h60;
	localparam logic [7:0]  CTL_RESUME = 8'hE0;
	localparam logic [7:0]  SEL_NONE   = 8'h00;

	// ==========================================================================
	// Audio processing coefficients.
	localparam int          COEF_NUM   = 4;
	localparam logic [1:0]  COEF_FIRST = 2'h0;
	localparam logic [1:0]  COEF_LAST  = 2'h3;
	localparam logic [7:0]  COEF_RESET = 8'h00;

	// ==========================================================================
	// Driver timing.
	localparam int          CLK_PERIOD_NS  = 10;
	localparam int          T_ENABLE_NS    = 50;
	localparam int          ENABLE_MAX_CYC = T_ENABLE_NS / CLK_PERIOD_NS;

	typedef enum logic [0:0] {
		LM_ADDR = 1'b0,
		LM_DATA = 1'b1
	} link_mode_e;

endpackage
